// ---- hdl/spln_pkg.sv ----
// Shared constants for the phy event log and queue-management command ends
package spln_pkg;
	// Command opcodes and log page numbers
	localparam logic [7:0] OPC_NCQ_NONDATA = 8'h63;
	localparam logic [7:0] LOG_PAGE_PHY = 8'h11;
	// Subcommand codes
	localparam logic [3:0] SUB_ABORT = 4'h0;
	localparam logic [3:0] SUB_DEADLINE = 4'h1;
	localparam logic [3:0] SUB_SETFEAT = 4'h5;
	// Abort type codes
	localparam logic [3:0] ATYPE_ALL = 4'h0;
	localparam logic [3:0] ATYPE_SELECTED = 4'h3;
	// Field positions in the command words
	localparam int FEAT_SUB_LSB = 0;
	localparam int FEAT_ATYPE_LSB = 4;
	localparam int CNT_TAG_LSB = 3;
	localparam int CNT_TTAG_LSB = 11;
	localparam int FEAT_LOGRST_BIT = 0;
	// Queue depth, tags at or above it are invalid
	localparam logic [5:0] NCQ_DEPTH = 6'h20;
	// Log page layout
	localparam logic [8:0] LAST_IDX = 9'h1FF;
	localparam int ID_SIZE_LSB = 12;
	localparam int NUM_CNT = 4;
	localparam logic [15:0] PEC_ID [NUM_CNT] = '{16'h1001, 16'h100A, 16'h2009, 16'h100B};
	localparam int PEC_PHYS_W [NUM_CNT] = '{8, 16, 20, 8};
	localparam int PEC_FBYTES [NUM_CNT] = '{2, 2, 4, 2};
	localparam int PEC_OFS [NUM_CNT] = '{4, 8, 12, 18};
	// Host register offsets
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_CMD = 5'h04;
	localparam logic [4:0] REG_STAT = 5'h08;
	localparam logic [4:0] REG_SDB = 5'h0C;
	// Host control bits
	localparam int CTRL_ISSUE = 0;
	localparam int CTRL_LOG = 1;
	localparam int CTRL_LOGRST = 2;
	localparam int CTRL_BIST = 3;
	// Host command register reset value
	localparam logic [31:0] CMD_RST = 32'h6300_0000;
endpackage

// ---- hdl/spln_if.sv ----
// Link between the host controller end and the device command end
interface spln_if;
	// Host to device
	logic cmd_valid;
	logic [7:0] cmd_opcode;
	logic [15:0] cmd_features;
	logic [15:0] cmd_count;
	logic log_req;
	logic [7:0] log_page;
	logic log_rst;
	logic log_ready;
	logic bist_activate;
	// Device to host
	logic dev_busy;
	logic cmd_done;
	logic cmd_err;
	logic cmd_abrt;
	logic sdb_valid;
	logic [31:0] sdb_act;
	logic log_valid;
	logic [7:0] log_data;
	logic log_last;
	modport dev (input cmd_valid, cmd_opcode, cmd_features, cmd_count, log_req, log_page,
		log_rst, log_ready, bist_activate,
		output dev_busy, cmd_done, cmd_err, cmd_abrt, sdb_valid, sdb_act, log_valid,
		log_data, log_last);
	modport host (output cmd_valid, cmd_opcode, cmd_features, cmd_count, log_req, log_page,
		log_rst, log_ready, bist_activate,
		input dev_busy, cmd_done, cmd_err, cmd_abrt, sdb_valid, sdb_act, log_valid,
		log_data, log_last);
endinterface

// ---- hdl/spln_dev.sv ----
// Device end: phy event counters, log page streamer and queue-management command
//
// The register addresses and the Avalon-MM interface to the registers were decided locally.
module spln_dev (
	// Clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic RST_B_IN,
	// Link to host
	spln_if.dev LINK,
	// Queue bookkeeping from command logic
	input wire logic NCQ_ENABLE_IN,
	input wire logic Q_ACCEPT_IN,
	input wire logic [4:0] Q_ACCEPT_TAG_IN,
	input wire logic Q_FINISH_IN,
	input wire logic [4:0] Q_FINISH_TAG_IN,
	// Phy event pulses
	input wire logic [spln_pkg::NUM_CNT-1:0] EVENT_IN,
	// Abort report
	output logic ABORT_VALID_OUT,
	output logic [31:0] ABORT_MASK_OUT,
	output logic [31:0] OUTSTANDING_OUT
);
	import spln_pkg::*;
	typedef enum logic [1:0] {ST_IDLE, ST_NCQ, ST_LOG} spln_state_e;
	spln_state_e state_reg; // Main sequencer
	logic busy_reg, done_reg, err_reg, abrt_reg; // Busy, done pulse, error and abort bits
	logic sdb_valid_reg, abort_valid_reg; // Set device bits and abort report pulses
	logic [31:0] sdb_act_reg, abort_mask_reg; // ACT bits and aborted tags
	logic log_valid_reg, log_last_reg; // Byte on offer, checksum byte marker
	logic [7:0] log_data_reg, sum_reg; // Byte value, running byte sum
	logic [8:0] idx_reg; // Next page byte index
	logic logrst_reg; // Clear after read
	logic [7:0] opc_reg; // Captured opcode
	logic [3:0] sub_reg, atype_reg; // Captured subcommand and abort type
	logic [4:0] tag_reg, ttag_reg; // Own and target tags
	logic [31:0] snapq_reg, out_reg; // Outstanding at acceptance, current outstanding
	logic [31:0] cnt [NUM_CNT], fld [NUM_CNT], snap [NUM_CNT]; // Counters, fields, snapshots
	logic clr_cnt, log_start, log_take, log_end; // Counter clear and stream strobes
	logic [7:0] cur_byte; // Byte for current index
	logic ev_err; // Command outcome error
	logic [31:0] ev_mask, own_bit, tt_bit; // Abort set, own and target one-hot
	// Link outputs straight from flops
	assign LINK.dev_busy = busy_reg;
	assign LINK.cmd_done = done_reg;
	assign LINK.cmd_err = err_reg;
	assign LINK.cmd_abrt = abrt_reg;
	assign LINK.sdb_valid = sdb_valid_reg;
	assign LINK.sdb_act = sdb_act_reg;
	assign LINK.log_valid = log_valid_reg;
	assign LINK.log_data = log_data_reg;
	assign LINK.log_last = log_last_reg;
	assign ABORT_VALID_OUT = abort_valid_reg;
	assign ABORT_MASK_OUT = abort_mask_reg;
	assign OUTSTANDING_OUT = out_reg;
	// Sequencing strobes
	assign log_start = (state_reg == ST_IDLE) && !busy_reg && LINK.log_req
		&& (LINK.log_page == LOG_PAGE_PHY);
	assign log_take = (state_reg == ST_LOG) && (!log_valid_reg || LINK.log_ready);
	assign log_end = log_take && log_valid_reg && log_last_reg;
	assign clr_cnt = LINK.bist_activate || (log_end && logrst_reg);
	// Per-counter saturating count, one-extension and snapshot
	generate
		for (genvar g = 0; g < NUM_CNT; g++) begin : g_cnt
			localparam logic [31:0] CMAX = 32'hFFFF_FFFF >> (32 - PEC_PHYS_W[g]);
			localparam logic [31:0] FMAX = 32'hFFFF_FFFF >> (32 - 8 * PEC_FBYTES[g]);
			// Count events, stop at the top
			always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
				if (!RST_B_IN) begin
					cnt[g] <= 32'h0000_0000;
				end else if (clr_cnt) begin
					cnt[g] <= 32'h0000_0000;
				end else if (EVENT_IN[g] && (cnt[g] != CMAX)) begin
					cnt[g] <= cnt[g] + 32'h0000_0001;
				end
			end
			// Saturated narrow counter fills the whole field
			assign fld[g] = (cnt[g] == CMAX) ? FMAX : cnt[g];
			// Freeze values when a read starts
			always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
				if (!RST_B_IN) begin
					snap[g] <= 32'h0000_0000;
				end else if (log_start) begin
					snap[g] <= fld[g];
				end
			end
		end
	endgenerate
	// Page byte for the current index, identifier then value, low byte first
	always_comb begin
		cur_byte = 8'h00;
		for (int i = 0; i < NUM_CNT; i++) begin
			for (int k = 0; k < 6; k++) begin
				if ((k < 2 + PEC_FBYTES[i]) && (idx_reg == 9'(PEC_OFS[i] + k))) begin
					cur_byte = 8'({snap[i], PEC_ID[i]} >> (8 * k));
				end
			end
		end
		if (idx_reg == LAST_IDX) begin
			cur_byte = 8'h00 - sum_reg;
		end
	end
	// Queue-management outcome
	always_comb begin
		own_bit = 32'h0000_0001 << tag_reg;
		tt_bit = 32'h0000_0001 << ttag_reg;
		ev_err = 1'b0;
		ev_mask = 32'h0000_0000;
		if ((opc_reg != OPC_NCQ_NONDATA) || !NCQ_ENABLE_IN) begin
			ev_err = 1'b1;
		end else begin
			case (sub_reg)
				SUB_ABORT: begin
					if ((ttag_reg == tag_reg) || ({1'b0, ttag_reg} >= NCQ_DEPTH)) begin
						ev_err = 1'b1;
					end else if (atype_reg == ATYPE_ALL) begin
						ev_mask = snapq_reg & ~own_bit;
					end else if (atype_reg == ATYPE_SELECTED) begin
						ev_mask = snapq_reg & tt_bit;
					end else begin
						ev_err = 1'b1;
					end
				end
				SUB_DEADLINE, SUB_SETFEAT: ev_err = 1'b0;
				default: begin
					ev_err = 1'b1;
					ev_mask = snapq_reg & ~own_bit;
				end
			endcase
		end
	end
	// Main sequencer and busy flag
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			state_reg <= ST_IDLE;
			busy_reg <= 1'b0;
		end else begin
			case (state_reg)
				ST_IDLE: begin
					if (!busy_reg && LINK.cmd_valid) begin
						state_reg <= ST_NCQ;
						busy_reg <= 1'b1;
					end else if (log_start) begin
						state_reg <= ST_LOG;
						busy_reg <= 1'b1;
					end
				end
				ST_LOG: begin
					if (log_end) begin
						state_reg <= ST_IDLE;
						busy_reg <= 1'b0;
					end
				end
				default: begin // One-cycle command state and stray codes
					state_reg <= ST_IDLE;
					busy_reg <= 1'b0;
				end
			endcase
		end
	end
	// Capture command fields and the outstanding set on acceptance
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			opc_reg <= 8'h00;
			sub_reg <= 4'h0;
			atype_reg <= 4'h0;
			tag_reg <= 5'h00;
			ttag_reg <= 5'h00;
			snapq_reg <= 32'h0000_0000;
			logrst_reg <= 1'b0;
		end else if ((state_reg == ST_IDLE) && !busy_reg && LINK.cmd_valid) begin
			opc_reg <= LINK.cmd_opcode;
			sub_reg <= LINK.cmd_features[FEAT_SUB_LSB +: 4];
			atype_reg <= LINK.cmd_features[FEAT_ATYPE_LSB +: 4];
			tag_reg <= LINK.cmd_count[CNT_TAG_LSB +: 5];
			ttag_reg <= LINK.cmd_count[CNT_TTAG_LSB +: 5];
			snapq_reg <= out_reg;
		end else if (log_start) begin
			logrst_reg <= LINK.log_rst;
		end
	end
	// Completion, status and set device bits
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			done_reg <= 1'b0;
			err_reg <= 1'b0;
			abrt_reg <= 1'b0;
			sdb_valid_reg <= 1'b0;
			sdb_act_reg <= 32'h0000_0000;
			abort_valid_reg <= 1'b0;
			abort_mask_reg <= 32'h0000_0000;
		end else begin
			done_reg <= 1'b0;
			sdb_valid_reg <= 1'b0;
			abort_valid_reg <= 1'b0;
			if (state_reg == ST_NCQ) begin
				done_reg <= 1'b1;
				err_reg <= ev_err;
				abrt_reg <= ev_err;
				sdb_valid_reg <= !ev_err;
				sdb_act_reg <= ev_err ? 32'h0000_0000 : (own_bit | ev_mask);
				abort_valid_reg <= 1'b1;
				abort_mask_reg <= ev_mask;
			end else if (log_end) begin
				done_reg <= 1'b1;
				err_reg <= 1'b0;
				abrt_reg <= 1'b0;
			end else if ((state_reg == ST_IDLE) && !busy_reg && !LINK.cmd_valid
				&& LINK.log_req && !log_start) begin
				// Unsupported log page
				done_reg <= 1'b1;
				err_reg <= 1'b1;
				abrt_reg <= 1'b1;
			end
		end
	end
	// Outstanding queue, new acceptance wins over clearing
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			out_reg <= 32'h0000_0000;
		end else begin
			out_reg <= (out_reg
				& ~((Q_FINISH_IN ? (32'h0000_0001 << Q_FINISH_TAG_IN) : 32'h0000_0000)
				| ((state_reg == ST_NCQ) ? ev_mask : 32'h0000_0000)))
				| (Q_ACCEPT_IN ? (32'h0000_0001 << Q_ACCEPT_TAG_IN) : 32'h0000_0000);
		end
	end
	// Page streamer with host back-pressure
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			log_valid_reg <= 1'b0;
			log_data_reg <= 8'h00;
			log_last_reg <= 1'b0;
			idx_reg <= 9'h000;
			sum_reg <= 8'h00;
		end else if (log_start) begin
			idx_reg <= 9'h000;
			sum_reg <= 8'h00;
		end else if (log_end) begin
			log_valid_reg <= 1'b0;
			log_last_reg <= 1'b0;
		end else if (log_take) begin
			log_valid_reg <= 1'b1;
			log_data_reg <= cur_byte;
			log_last_reg <= (idx_reg == LAST_IDX);
			sum_reg <= sum_reg + cur_byte;
			idx_reg <= idx_reg + 9'h001;
		end
	end
endmodule

// ---- hdl/spln_host.sv ----
// Host end: Avalon-MM command registers driving the link and parsing the log page
module spln_host (
	// Clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic RST_B_IN,
	// Avalon-MM slave
	input wire logic [4:0] AVS_ADDRESS_IN,
	input wire logic AVS_READ_IN,
	input wire logic AVS_WRITE_IN,
	input wire logic [31:0] AVS_WRITEDATA_IN,
	output logic [31:0] AVS_READDATA_OUT,
	output logic AVS_WAITREQUEST_OUT,
	// Link to device
	spln_if.host LINK
);
	import spln_pkg::*;

	typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} spln_hstate_e;

	spln_hstate_e state_reg; // Host sequencer
	logic wait_reg; // Waitrequest flop
	logic [31:0] rdata_reg; // Read data
	logic [31:0] cmd_reg; // Command fields
	logic op_log_reg; // Current op is a log read
	logic logrst_reg; // Clear counters after read
	logic bist_reg; // BIST pulse
	logic cmd_valid_reg; // Command pulse
	logic log_req_reg; // Log request pulse
	logic ready_reg; // Accepting log bytes
	logic done_reg; // Sticky done
	logic err_reg; // Status error
	logic abrt_reg; // Abort error
	logic csum_ok_reg; // Page checksum good
	logic [31:0] sdb_reg; // Last ACT bits
	logic parse_reg; // Still walking entries
	logic [9:0] nxt_reg; // Next identifier position
	logic [9:0] pos_reg; // Byte position
	logic [7:0] lo_reg; // Identifier low byte
	logic [7:0] sum_reg; // Byte sum
	logic [7:0] ents_reg; // Entries found
	logic acc; // Request seen while waitrequest is high
	logic go; // Start request from software
	logic byte_in; // Log byte taken
	logic [15:0] id_word; // Assembled identifier

	assign LINK.cmd_valid = cmd_valid_reg;
	assign LINK.cmd_opcode = cmd_reg[31:24];
	assign LINK.cmd_features = {8'h00, cmd_reg[7:4], cmd_reg[3:0]};
	assign LINK.cmd_count = {cmd_reg[20:16], 3'b000, cmd_reg[12:8], 3'b000};
	assign LINK.log_req = log_req_reg;
	assign LINK.log_page = LOG_PAGE_PHY;
	assign LINK.log_rst = logrst_reg;
	assign LINK.log_ready = ready_reg;
	assign LINK.bist_activate = bist_reg;
	assign AVS_READDATA_OUT = rdata_reg;
	assign AVS_WAITREQUEST_OUT = wait_reg;

	// Request raises the answer; a write lands only at the edge with waitrequest low
	assign acc = (AVS_READ_IN || AVS_WRITE_IN) && wait_reg;
	assign go = !wait_reg && AVS_WRITE_IN && (AVS_ADDRESS_IN == REG_CTRL)
		&& (state_reg == H_IDLE);
	assign byte_in = LINK.log_valid && ready_reg;
	assign id_word = {LINK.log_data, lo_reg};

	// One wait state per access, then read data
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			wait_reg <= 1'b1;
			rdata_reg <= 32'h0000_0000;
		end else begin
			wait_reg <= !acc;
			if (acc && AVS_READ_IN) begin
				case (AVS_ADDRESS_IN)
					REG_CMD: rdata_reg <= cmd_reg;
					REG_STAT: rdata_reg <= {16'h0000, ents_reg, 3'b000, csum_ok_reg,
						abrt_reg, err_reg, done_reg, (state_reg != H_IDLE)};
					REG_SDB: rdata_reg <= sdb_reg;
					default: rdata_reg <= 32'h0000_0000;
				endcase
			end
		end
	end

	// Command register
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			cmd_reg <= CMD_RST;
		end else if (!wait_reg && AVS_WRITE_IN && (AVS_ADDRESS_IN == REG_CMD)) begin
			cmd_reg <= AVS_WRITEDATA_IN;
		end
	end

	// Sequencer, link strobes and results
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			state_reg <= H_IDLE;
			op_log_reg <= 1'b0;
			logrst_reg <= 1'b0;
			bist_reg <= 1'b0;
			cmd_valid_reg <= 1'b0;
			log_req_reg <= 1'b0;
			ready_reg <= 1'b0;
			done_reg <= 1'b0;
			err_reg <= 1'b0;
			abrt_reg <= 1'b0;
			sdb_reg <= 32'h0000_0000;
		end else begin
			cmd_valid_reg <= 1'b0;
			log_req_reg <= 1'b0;
			bist_reg <= go && AVS_WRITEDATA_IN[CTRL_BIST];
			case (state_reg)
				H_IDLE: begin
					if (go && (AVS_WRITEDATA_IN[CTRL_ISSUE] || AVS_WRITEDATA_IN[CTRL_LOG])) begin
						state_reg <= H_ISSUE;
						op_log_reg <= !AVS_WRITEDATA_IN[CTRL_ISSUE];
						logrst_reg <= AVS_WRITEDATA_IN[CTRL_LOGRST];
						done_reg <= 1'b0;
					end
				end
				H_ISSUE: begin
					if (!LINK.dev_busy) begin
						cmd_valid_reg <= !op_log_reg;
						log_req_reg <= op_log_reg;
						ready_reg <= op_log_reg;
						state_reg <= H_WAIT;
					end
				end
				H_WAIT: begin
					if (LINK.cmd_done) begin
						state_reg <= H_IDLE;
						ready_reg <= 1'b0;
						done_reg <= 1'b1;
						err_reg <= LINK.cmd_err;
						abrt_reg <= LINK.cmd_abrt;
					end
					if (LINK.sdb_valid) begin
						sdb_reg <= LINK.sdb_act;
					end
				end
				default: begin
					state_reg <= H_IDLE;
				end
			endcase
		end
	end

	// Walk the page: entries until a zero identifier or the end
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			parse_reg <= 1'b0;
			nxt_reg <= 10'h004;
			pos_reg <= 10'h000;
			lo_reg <= 8'h00;
			sum_reg <= 8'h00;
			ents_reg <= 8'h00;
			csum_ok_reg <= 1'b0;
		end else if (log_req_reg) begin
			parse_reg <= 1'b1;
			nxt_reg <= 10'h004;
			pos_reg <= 10'h000;
			sum_reg <= 8'h00;
			ents_reg <= 8'h00;
			csum_ok_reg <= 1'b0;
		end else if (byte_in) begin
			pos_reg <= pos_reg + 10'h001;
			sum_reg <= sum_reg + LINK.log_data;
			if (parse_reg && (pos_reg == nxt_reg)) begin
				lo_reg <= LINK.log_data;
			end else if (parse_reg && (pos_reg == nxt_reg + 10'h001)) begin
				if (id_word == 16'h0000) begin
					parse_reg <= 1'b0;
				end else begin
					ents_reg <= ents_reg + 8'h01;
					nxt_reg <= nxt_reg + 10'h002
						+ {6'h00, id_word[ID_SIZE_LSB +: 3], 1'b0};
				end
			end
			if (LINK.log_last) begin
				csum_ok_reg <= ((sum_reg + LINK.log_data) == 8'h00);
				parse_reg <= 1'b0;
			end
		end
	end
endmodule

// ---- sim/spln_props.sv ----
// Link-side assertions for the phy log and queue-management ends
module spln_props (
	// Clock and reset
	input wire logic CLK_SYS_IN,
	input wire logic RST_B_IN,
	// Host to device
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic [15:0] cmd_features,
	input wire logic [15:0] cmd_count,
	input wire logic log_req,
	input wire logic [7:0] log_page,
	input wire logic log_ready,
	// Device to host
	input wire logic dev_busy,
	input wire logic cmd_done,
	input wire logic cmd_err,
	input wire logic cmd_abrt,
	input wire logic sdb_valid,
	input wire logic [31:0] sdb_act,
	input wire logic log_valid,
	input wire logic [7:0] log_data,
	input wire logic log_last
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge CLK_SYS_IN); endclocking
	default disable iff (!RST_B_IN);
	logic [8:0] idx_reg; // Byte position in the stream
	logic [7:0] sum_reg; // Running byte sum
	wire logic take = log_valid && log_ready; // Byte handed over
	// Track position and sum of the page
	always_ff @(posedge CLK_SYS_IN or negedge RST_B_IN) begin
		if (!RST_B_IN) begin
			idx_reg <= 9'h000;
			sum_reg <= 8'h00;
		end else if (take) begin
			idx_reg <= log_last ? 9'h000 : idx_reg + 9'h001;
			sum_reg <= log_last ? 8'h00 : sum_reg + log_data;
		end
	end
	// Abort subcommand accepted by an idle device
	sequence s_issue;
		cmd_valid && !dev_busy && cmd_opcode == 8'h63 && cmd_features[3:0] == 4'h0;
	endsequence
	// Refusal two cycles on
	sequence s_refuse;
		##2 cmd_done && cmd_err && cmd_abrt && !sdb_valid;
	endsequence
	opc_refuse_a: assert property (cmd_valid && !dev_busy && cmd_opcode != 8'h63 |-> s_refuse)
		else $error("foreign opcode not refused");
	sub_refuse_a: assert property (cmd_valid && !dev_busy &&
		!(cmd_features[3:0] inside {4'h0, 4'h1, 4'h5}) |-> s_refuse)
		else $error("bad subcommand not refused");
	own_tag_a: assert property (s_issue ##0 cmd_count[15:11] == cmd_count[7:3] |-> s_refuse)
		else $error("own target tag not refused");
	bad_type_a: assert property (s_issue ##0 !(cmd_features[7:4] inside {4'h0, 4'h3}) |-> s_refuse)
		else $error("bad abort type not refused");
	abort_now_a: assert property (s_issue |-> ##1 dev_busy ##1 cmd_done && !dev_busy)
		else $error("abort not immediate");
	sdb_own_a: assert property (sdb_valid |-> cmd_done && !cmd_err && sdb_act[$past(cmd_count[7:3], 2)])
		else $error("own act bit missing");
	log_start_a: assert property (log_req && !cmd_valid && !dev_busy && log_page == 8'h11 |->
		##1 dev_busy && !log_valid ##1 log_valid)
		else $error("log stream late");
	log_len_a: assert property (take && log_last |-> idx_reg == 9'h1FF)
		else $error("page length wrong");
	log_hold_a: assert property (log_valid && !log_ready |=> log_valid && $stable(log_data))
		else $error("byte dropped under stall");
	hdr_zero_a: assert property (log_valid && idx_reg < 9'h004 |-> log_data == 8'h00)
		else $error("header not zero");
	tail_zero_a: assert property (log_valid && idx_reg >= 9'h016 && idx_reg < 9'h1FF |->
		log_data == 8'h00)
		else $error("data after terminator");
	csum_a: assert property (take && log_last |-> sum_reg + log_data == 8'h00)
		else $error("page sum not zero");
	log_end_a: assert property (take && log_last |=> cmd_done && !log_valid)
		else $error("stream not closed");
endmodule

// ---- sim/spln_tb.sv ----
// Bench joining host and device ends, driven through the Avalon registers
module spln_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import spln_pkg::*;
	logic clk_sys, rst_b, avs_read, avs_write, avs_waitrequest, ncq_en, q_acc, q_fin, abort_valid;
	logic [4:0] avs_address, q_acc_tag, q_fin_tag;
	logic [31:0] avs_writedata, avs_readdata, abort_mask, outstanding, rdata;
	logic [3:0] ev;
	logic [7:0] page [512]; // Captured log page
	int nbytes, miscompares, checks_done, aborts;
	always #5 clk_sys = ~clk_sys;
	spln_if spln_if_i ();
	spln_dev spln_dev_i (.CLK_SYS_IN(clk_sys), .RST_B_IN(rst_b), .LINK(spln_if_i),
		.NCQ_ENABLE_IN(ncq_en), .Q_ACCEPT_IN(q_acc), .Q_ACCEPT_TAG_IN(q_acc_tag),
		.Q_FINISH_IN(q_fin), .Q_FINISH_TAG_IN(q_fin_tag), .EVENT_IN(ev),
		.ABORT_VALID_OUT(abort_valid), .ABORT_MASK_OUT(abort_mask), .OUTSTANDING_OUT(outstanding));
	spln_host spln_host_i (.CLK_SYS_IN(clk_sys), .RST_B_IN(rst_b), .AVS_ADDRESS_IN(avs_address),
		.AVS_READ_IN(avs_read), .AVS_WRITE_IN(avs_write), .AVS_WRITEDATA_IN(avs_writedata),
		.AVS_READDATA_OUT(avs_readdata), .AVS_WAITREQUEST_OUT(avs_waitrequest), .LINK(spln_if_i));
	spln_props spln_props_i (.CLK_SYS_IN(clk_sys), .RST_B_IN(rst_b),
		.cmd_valid(spln_if_i.cmd_valid), .cmd_opcode(spln_if_i.cmd_opcode),
		.cmd_features(spln_if_i.cmd_features), .cmd_count(spln_if_i.cmd_count),
		.log_req(spln_if_i.log_req), .log_page(spln_if_i.log_page), .log_ready(spln_if_i.log_ready),
		.dev_busy(spln_if_i.dev_busy), .cmd_done(spln_if_i.cmd_done), .cmd_err(spln_if_i.cmd_err),
		.cmd_abrt(spln_if_i.cmd_abrt), .sdb_valid(spln_if_i.sdb_valid), .sdb_act(spln_if_i.sdb_act),
		.log_valid(spln_if_i.log_valid), .log_data(spln_if_i.log_data),
		.log_last(spln_if_i.log_last));
	// Capture every byte taken on the link and count abort reports
	always @(posedge clk_sys) begin
		if (abort_valid === 1'b1)
			aborts = aborts + 1;
		if (spln_if_i.log_valid && spln_if_i.log_ready && nbytes < 512) begin
			page[nbytes] = spln_if_i.log_data;
			nbytes = nbytes + 1;
		end
	end
	// Verdict and end of run
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
		checks_done++;
		if (got !== exp) begin
			$display("FAIL %s expected %h seen %h", what, exp, got);
			miscompares++;
		end
	endtask
	// One Avalon transfer, held until waitrequest is sampled low
	task automatic av(input logic wr, input logic [4:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		@(posedge clk_sys);
		avs_address <= a;
		avs_writedata <= d;
		avs_write <= wr;
		avs_read <= !wr;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys);
			if (avs_waitrequest === 1'b0) break;
		end
		q = avs_readdata;
		avs_write <= 1'b0;
		avs_read <= 1'b0;
		if (n == 50) begin
			miscompares++;
			stop_test();
		end
	endtask
	// Start an operation and poll status until done
	task automatic run_op(input logic [31:0] ctrl);
		int n;
		av(1'b1, REG_CTRL, ctrl, rdata);
		for (n = 0; n < 400; n++) begin
			av(1'b0, REG_STAT, 32'h0, rdata);
			if (rdata[1:0] === 2'b10) break;
		end
		if (n == 400) begin
			miscompares++;
			stop_test();
		end
	endtask
	function automatic logic [31:0] mk(input logic [7:0] op, input logic [4:0] tt,
		input logic [4:0] own, input logic [3:0] at, input logic [3:0] sb);
		return {op, 3'h0, tt, 3'h0, own, at, sb};
	endfunction
	// Queue-management command with expected outcome; all-ones mask skips mask check
	task automatic ncq(input logic [31:0] cmd, input logic err, input logic [31:0] sdb,
		input logic [31:0] mask);
		int n0;
		n0 = aborts;
		av(1'b1, REG_CMD, cmd, rdata);
		run_op(32'h1);
		chk("abort reports", n0 + 1, aborts);
		chk("error bits", {err, err}, rdata[3:2]);
		if (mask !== 32'hFFFF_FFFF)
			chk("abort mask", mask, abort_mask);
		if (!err) begin
			av(1'b0, REG_SDB, 32'h0, rdata);
			chk("act bits", sdb, rdata);
		end
	endtask
	task automatic tagq(input logic fin, input logic [4:0] t);
		@(posedge clk_sys);
		q_acc <= !fin;
		q_fin <= fin;
		q_acc_tag <= t;
		q_fin_tag <= t;
		@(posedge clk_sys);
		q_acc <= 1'b0;
		q_fin <= 1'b0;
	endtask
	// Accept a tag just after the command is taken
	task automatic late_accept(input logic [4:0] t);
		int n;
		for (n = 0; n < 50; n++) begin
			@(posedge clk_sys);
			if (spln_if_i.cmd_valid === 1'b1) break;
		end
		if (n == 50) miscompares++;
		q_acc <= 1'b1;
		q_acc_tag <= t;
		@(posedge clk_sys);
		q_acc <= 1'b0;
	endtask
	// Read the page and parse it entry by entry
	task automatic log_read(input logic [31:0] ctrl, input logic [63:0] vals [NUM_CNT]);
		int ofs, nb, bad;
		logic [15:0] id;
		logic [63:0] v;
		logic [7:0] sum;
		nbytes = 0;
		run_op(ctrl);
		chk("page length", 512, nbytes);
		chk("header", 0, {page[3], page[2], page[1], page[0]});
		ofs = 4;
		for (int k = 0; k < NUM_CNT; k++) begin
			id = {page[ofs + 1], page[ofs]};
			chk("identifier", PEC_ID[k], id);
			nb = 2 * id[14:12];
			v = 64'h0;
			for (int b = 0; b < nb && b < 8; b++)
				v[8 * b +: 8] = page[ofs + 2 + b];
			chk("counter value", vals[k], v);
			ofs = ofs + 2 + nb;
		end
		chk("terminator", 0, {page[ofs + 1], page[ofs]});
		sum = 8'h00;
		bad = 0;
		for (int k = 0; k < 512; k++) begin
			if (k >= ofs && k < 511 && page[k] !== 8'h00)
				bad++;
			sum = sum + page[k];
		end
		chk("zero fill", 0, bad);
		chk("page sum", 0, sum);
		av(1'b0, REG_STAT, 32'h0, rdata);
		chk("sum flag", 1, rdata[4]);
		chk("entries", NUM_CNT, rdata[15:8]);
	endtask
	task automatic t_log();
		logic [63:0] vals [NUM_CNT];
		ev <= 4'b0111;
		repeat (3) @(posedge clk_sys);
		ev <= 4'b0011;
		repeat (2) @(posedge clk_sys);
		ev <= 4'b0001;
		repeat (295) @(posedge clk_sys);
		ev <= 4'b0000;
		vals = '{64'hFFFF, 64'h5, 64'h3, 64'h0};
		log_read(32'h6, vals);
		vals = '{default: 64'h0};
		log_read(32'h2, vals);
		ev <= 4'b1000;
		@(posedge clk_sys);
		ev <= 4'b0000;
		av(1'b1, REG_CTRL, 32'h8, rdata);
		log_read(32'h2, vals);
		$display("test log done");
	endtask
	task automatic t_ncq();
		ncq_en <= 1'b1;
		tagq(0, 1);
		tagq(0, 2);
		tagq(0, 5);
		tagq(0, 9);
		tagq(1, 5);
		@(posedge clk_sys);
		chk("outstanding", 32'h206, outstanding);
		ncq(mk(8'h63, 5'd0, 5'd1, ATYPE_ALL, SUB_ABORT), 1'b0, 32'h206, 32'h204);
		tagq(0, 3);
		tagq(0, 7);
		ncq(mk(8'h63, 5'd7, 5'd4, ATYPE_SELECTED, SUB_ABORT), 1'b0, 32'h90, 32'h80);
		ncq(mk(8'h63, 5'd12, 5'd4, ATYPE_SELECTED, SUB_ABORT), 1'b0, 32'h10, 32'h0);
		tagq(1, 1);
		fork
			ncq(mk(8'h63, 5'd0, 5'd6, ATYPE_ALL, SUB_ABORT), 1'b0, 32'h48, 32'h8);
			late_accept(5'd20);
		join
		chk("late tag kept", 32'h0010_0000, outstanding);
		$display("test queue done");
	endtask
	task automatic t_err();
		logic [3:0] subs [5];
		logic [3:0] types [4];
		subs = '{4'h2, 4'h3, 4'h4, 4'h6, 4'hF};
		types = '{4'h1, 4'h2, 4'h4, 4'hF};
		ncq(mk(8'h63, 5'd9, 5'd2, ATYPE_ALL, 4'h2), 1'b1, 0, 32'h0010_0000);
		chk("outstanding", 0, outstanding);
		foreach (subs[i])
			ncq(mk(8'h63, 5'd9, 5'd2, ATYPE_ALL, subs[i]), 1'b1, 0, 0);
		foreach (types[i])
			ncq(mk(8'h63, 5'd9, 5'd2, types[i], SUB_ABORT), 1'b1, 0, 0);
		ncq(mk(8'h63, 5'd7, 5'd7, ATYPE_SELECTED, SUB_ABORT), 1'b1, 0, 0);
		ncq(mk(8'h60, 5'd9, 5'd2, ATYPE_ALL, SUB_ABORT), 1'b1, 0, '1);
		ncq(mk(8'h63, 5'd9, 5'd2, ATYPE_ALL, SUB_DEADLINE), 1'b0, 32'h4, 0);
		ncq(mk(8'h63, 5'd9, 5'd2, ATYPE_ALL, SUB_SETFEAT), 1'b0, 32'h4, 0);
		ncq_en <= 1'b0;
		ncq(mk(8'h63, 5'd9, 5'd2, ATYPE_ALL, SUB_ABORT), 1'b1, 0, '1);
		$display("test errors done");
	endtask
	// Reset, then scenarios in turn
	initial begin
		{clk_sys, rst_b, avs_read, avs_write, ncq_en, q_acc, q_fin} = '0;
		{avs_address, q_acc_tag, q_fin_tag, avs_writedata, ev} = '0;
		{nbytes, miscompares, checks_done, aborts} = '0;
		repeat (10) @(posedge clk_sys);
		rst_b <= 1'b1;
		av(1'b0, REG_CMD, 32'h0, rdata);
		chk("command reset", CMD_RST, rdata);
		av(1'b0, 5'h10, 32'h0, rdata);
		chk("unmapped", 0, rdata);
		t_log();
		t_ncq();
		t_err();
		stop_test();
	end
endmodule
